// file: tb/isa_dio_decode_irq_tb.sv
// Self-checking bench for the host I/O decode and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.svh"

module isa_dio_decode_irq_tb;
  import dio_pkg::*;
  logic        mclk, rst, ior_n, iow_n, sd_oe, hoe;
  logic [9:0]  sa;
  logic [7:0]  sd_in, sd_out, s_axi_awaddr, s_axi_araddr, hq;
  logic [5:0]  irq_out, irq_oe;
  logic [15:0] isolated_input, ttl_input, isolated_output, ttl_output;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_errors, checks_done;

  isa_dio_decode_irq i_dut (
    .mclk, .rst, .sa, .ior_n, .iow_n, .sd_in, .sd_out, .sd_oe, .irq_out, .irq_oe,
    .isolated_input, .ttl_input, .isolated_output, .ttl_output,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  isa_host_model i_host (.mclk, .sa, .ior_n, .iow_n, .sd_in, .sd_out, .sd_oe);

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // One AXI transfer; ready sampled at the falling edge, so the take is known in advance
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic [4:0] t;
    @(posedge mclk);
    if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge mclk);
      t = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready,
           s_axi_bready && s_axi_bvalid, s_axi_arvalid && s_axi_arready,
           s_axi_rready && s_axi_rvalid};
      if (t[2]) r = s_axi_bresp;
      if (t[0]) {q, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge mclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <=
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} & ~t;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready || s_axi_arvalid || s_axi_rready);
  endtask : axi

  task automatic set_src(input int s, input logic v);
    @(posedge mclk);
    if (s < 2) isolated_input[s] <= v;
    else ttl_input[s-2] <= v;
  endtask : set_src

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    axi(1'b0, `AXI_OFS_CFG, '0);
    check("cfg reset", q & 32'h0003_17ff, 32'h0000_06c0);
    check("irq_oe reset", irq_oe, '0);
    axi(1'b0, `AXI_OFS_STATE, '0);
    check("state idle", q, 32'h0000_0000);
    axi(1'b0, 8'h10, '0);
    check("unmapped resp", r, `AXI_RESP_DECERR);
  endtask : t_reset

  task automatic t_ports();
    for (int p = 0; p < 4; p++) i_host.io_cycle(1'b1, 10'h300 + 10'(p), 8'(8'ha0 + 8'h11 * p), hq, hoe);
    check("iso out", isolated_output, 16'hb1a0);
    check("ttl out", ttl_output, 16'hd3c2);
    isolated_input <= 16'h3c96;
    ttl_input <= 16'h1e87;
    for (int p = 0; p < 4; p++) begin
      i_host.io_cycle(1'b0, 10'h300 + 10'(p), 8'h00, hq, hoe);
      check("port read", {hoe, hq}, {1'b1, 8'({ttl_input, isolated_input} >> (8 * p))});
    end
  endtask : t_ports

  // Foreign addresses, bases below and above range, top of range and selector bit order
  task automatic t_ignore();
    logic [7:0]  bases [4] = '{8'h40, 8'hfc, 8'h81, 8'hfd};
    logic [9:0]  addrs [4] = '{10'h101, 10'h3f1, 10'h205, 10'h3f4};
    logic [15:0] exps  [4] = '{16'hb1a0, 16'h5ea0, 16'h80a0, 16'h80a0};
    i_host.io_cycle(1'b1, 10'h304, 8'hff, hq, hoe);
    i_host.io_cycle(1'b1, 10'h2ff, 8'hff, hq, hoe);
    i_host.io_cycle(1'b0, 10'h304, 8'h00, hq, hoe);
    check("foreign drive", hoe, 1'b0);
    check("foreign", {isolated_output, ttl_output}, 32'hb1a0_d3c2);
    for (int i = 0; i < 4; i++) begin
      axi(1'b1, `AXI_OFS_CFG, {24'h000006, bases[i]});
      i_host.io_cycle(1'b1, addrs[i], 8'(8'h3c + 8'h22 * i), hq, hoe);
      check("base", isolated_output, exps[i]);
    end
  endtask : t_ignore

  // Every level, every source, both edges; then disabled and masked
  task automatic t_irq();
    axi(1'b1, `AXI_OFS_MASK, 32'h1);
    check("write resp", r, `AXI_RESP_OKAY);
    for (int l = 0; l < 6; l++) begin
      set_src(l % 4, 1'(l % 2));
      axi(1'b1, `AXI_OFS_CFG, 32'h0c0 | (32'(l) << 8) | (32'(l % 2) << 12) | (32'(l % 4) << 16));
      repeat (10) @(posedge mclk);
      axi(1'b0, `AXI_OFS_STATUS, '0);
      repeat (4) @(posedge mclk);
      check("irq idle", irq_out, '0);
      set_src(l % 4, 1'(~l % 2));
      repeat (10) @(posedge mclk);
      check("irq line", {irq_oe, irq_out}, {6'(1 << l), 6'(1 << l)});
      axi(1'b0, `AXI_OFS_STATUS, '0);
      check("status edge", q[0], 1'b1);
      set_src(l % 4, 1'(l % 2));
      repeat (10) @(posedge mclk);
      check("wrong edge", irq_out, '0);
    end
    axi(1'b1, `AXI_OFS_CFG, 32'h6c0);
    set_src(0, 1'b1);
    repeat (10) @(posedge mclk);
    check("irq disabled", {irq_oe, irq_out}, 12'h000);
    axi(1'b1, `AXI_OFS_MASK, 32'h0);
    axi(1'b1, `AXI_OFS_CFG, 32'h0c0);
    repeat (4) @(posedge mclk);
    check("irq masked", irq_out, '0);
  endtask : t_irq

  // Watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  // Reset for 8 clocks, then the scenarios
  initial begin
    {mclk, rst, isolated_input, ttl_input, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {2'b01, 80'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_ports();
    t_ignore();
    t_irq();
    tally_and_finish();
  end
endmodule : isa_dio_decode_irq_tb
`default_nettype wire

// file: tb/isa_host_model.sv
// Host processor model issuing I/O read and write cycles to the card
`timescale 1ns/10ps
`default_nettype none

module isa_host_model (
  input  wire logic       mclk,
  output logic [9:0]      sa,
  output logic            ior_n,
  output logic            iow_n,
  output logic [7:0]      sd_in,
  input  wire logic [7:0] sd_out,
  input  wire logic       sd_oe
);
  // Idle bus at time zero, both strobes inactive
  initial begin
    sa    = 10'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    sd_in = 8'h00;
  end

  // One cycle; strobe held long enough for the two-flop synchroniser
  task automatic io_cycle(input logic wr, input logic [9:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
    @(posedge mclk);
    sa    <= a;
    sd_in <= d;
    if (wr) iow_n <= 1'b0;
    else ior_n <= 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    q  = sd_out;
    oe = sd_oe;
    @(posedge mclk);
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // Released lines must not keep the last value
    sa    <= ~a;
    sd_in <= ~d;
    repeat (3) @(posedge mclk);
  endtask : io_cycle
endmodule : isa_host_model
`default_nettype wire

// file: verilog/axi_cfg_regs.sv
// AXI4-Lite slave holding selectors, interrupt mask and sticky status
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.svh"

module axi_cfg_regs (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire dio_pkg::evt_t      evt,
  input  wire logic [2:0]         live_state,
  output dio_pkg::base_sel_t      base_sel,
  output dio_pkg::irq_level_t     irq_level,
  output logic                    edge_fall,
  output dio_pkg::src_sel_t       src_sel,
  output logic                    irq_req
);
  import dio_pkg::*;

  cfg_st_t st_ff;
  cfg_st_t nxt_st;

  // Word view of the configuration register
  function automatic logic [31:0] cfg_word(input cfg_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CFG_BASE_LSB +: 8] = s.base_sel;
    w[`CFG_LEVEL_LSB +: 3] = s.irq_level;
    w[`CFG_EDGE_BIT] = s.edge_fall;
    w[`CFG_SRC_LSB +: 2] = s.src_sel;
    return w;
  endfunction : cfg_word

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Handshakes are combinational; one write and one read in flight
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign base_sel      = st_ff.base_sel;
  assign irq_level     = st_ff.irq_level;
  assign edge_fall     = st_ff.edge_fall;
  assign src_sel       = st_ff.src_sel;
  assign irq_req       = st_ff.irq_req;

  // Next state: address and data taken in either order, then response
  always_comb begin
    logic [31:0] w;
    logic        rd_clr;
    w = 32'h0000_0000;
    rd_clr = 1'b0;
    nxt_st = st_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (nxt_st.aw_got && nxt_st.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `AXI_RESP_OKAY;
      unique case ({nxt_st.aw_addr[7:2], 2'b00})
        `AXI_OFS_CFG: begin
          w = merge(cfg_word(st_ff), nxt_st.w_data, nxt_st.w_strb);
          nxt_st.base_sel = w[`CFG_BASE_LSB +: 8];
          nxt_st.irq_level = w[`CFG_LEVEL_LSB +: 3];
          nxt_st.edge_fall = w[`CFG_EDGE_BIT];
          nxt_st.src_sel = w[`CFG_SRC_LSB +: 2];
        end
        `AXI_OFS_MASK: begin
          if (nxt_st.w_strb[0]) begin
            nxt_st.mask = nxt_st.w_data[1:0];
          end
        end
        `AXI_OFS_STATUS, `AXI_OFS_STATE: ;
        default: nxt_st.bresp = `AXI_RESP_DECERR;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `AXI_RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `AXI_OFS_CFG:    nxt_st.rdata = cfg_word(st_ff);
        `AXI_OFS_MASK:   nxt_st.rdata[1:0] = st_ff.mask;
        `AXI_OFS_STATUS: begin
          nxt_st.rdata[1:0] = st_ff.status;
          rd_clr = 1'b1;
        end
        `AXI_OFS_STATE:  nxt_st.rdata[2:0] = live_state;
        default:         nxt_st.rresp = `AXI_RESP_DECERR;
      endcase
    end
    // Read clears what it returned; a new event in that cycle survives
    nxt_st.status = (rd_clr ? 2'b00 : st_ff.status) | evt;
    nxt_st.irq_req = |(nxt_st.status & nxt_st.mask);
  end

  // Register the whole state
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.base_sel <= `BASE_SEL_RESET;
      st_ff.irq_level <= `IRQ_LEVEL_RESET;
      st_ff.edge_fall <= `EDGE_FALL_RESET;
      st_ff.src_sel <= `SRC_SEL_RESET;
      st_ff.mask <= `MASK_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : axi_cfg_regs
`default_nettype wire

// file: verilog/dio_defines.svh
// Offsets, field positions, reset values and counts of the I/O decode block
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ****************************************************************
// Host I/O block: four byte ports above the base
// ****************************************************************
`define ISA_OFS_ISO_LO   2'h0
`define ISA_OFS_ISO_HI   2'h1
`define ISA_OFS_TTL_LO   2'h2
`define ISA_OFS_TTL_HI   2'h3
`define BASE_SEL_RESET   8'hc0
`define BASE_SEL_MAX     8'hfc
`define BASE_RANGE_BIT   7
`define IRQ_LINES        6
`define IRQ_LEVEL_OFF    3'h6
`define IRQ_LEVEL_RESET  3'h6
`define EDGE_FALL_RESET  1'b0
`define SRC_SEL_RESET    2'h0

// ****************************************************************
// Configuration port map and fields
// ****************************************************************
`define AXI_OFS_CFG      8'h00
`define AXI_OFS_MASK     8'h04
`define AXI_OFS_STATUS   8'h08
`define AXI_OFS_STATE    8'h0c
`define CFG_BASE_LSB     0
`define CFG_LEVEL_LSB    8
`define CFG_EDGE_BIT     12
`define CFG_SRC_LSB      16
`define EVT_EDGE_BIT     0
`define EVT_WRITE_BIT    1
`define MASK_RESET       2'h0
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_DECERR  2'b11

`endif

// file: verilog/dio_pkg.sv
// Types shared by the I/O decode block and its configuration registers
package dio_pkg;
  typedef logic [7:0] base_sel_t;
  typedef logic [2:0] irq_level_t;
  typedef logic [1:0] src_sel_t;
  typedef logic [1:0] evt_t;

  // Host cycle tracker, one-hot
  typedef enum logic [2:0] {
    ISA_IDLE  = 3'b001,
    ISA_READ  = 3'b010,
    ISA_WRITE = 3'b100
  } isa_state_t;

  // Register-side state of the configuration slave
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    base_sel_t   base_sel;
    irq_level_t  irq_level;
    logic        edge_fall;
    src_sel_t    src_sel;
    evt_t        mask;
    evt_t        status;
    logic        irq_req;
  } cfg_st_t;
endpackage : dio_pkg

// file: verilog/isa_dio_decode_irq.sv
// Host I/O port decode, 32-channel output latches and edge interrupt
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dio_defines.svh"

module isa_dio_decode_irq (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [9:0]  sa,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic [7:0]  sd_in,
  output logic [7:0]       sd_out,
  output logic             sd_oe,
  output logic [5:0]       irq_out,
  output logic [5:0]       irq_oe,
  input  wire logic [15:0] isolated_input,
  input  wire logic [15:0] ttl_input,
  output logic [15:0]      isolated_output,
  output logic [15:0]      ttl_output,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import dio_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [9:0]  sa_s1;
    logic [9:0]  sa_s2;
    logic [7:0]  sd_s1;
    logic [7:0]  sd_s2;
    logic        ior_n_s1;
    logic        ior_n_s2;
    logic        iow_n_s1;
    logic        iow_n_s2;
    logic [15:0] iso_s1;
    logic [15:0] iso_s2;
    logic [15:0] ttl_s1;
    logic [15:0] ttl_s2;
    isa_state_t  fsm;
    logic [1:0]  wr_port;
    logic [7:0]  wr_data;
    logic [1:0]  rd_port;
    logic [7:0]  rd_data;
    logic        rd_oe;
    logic [15:0] iso_out;
    logic [15:0] ttl_out;
    logic        src_prev;
    logic        edge_ev;
    logic        wr_ev;
    logic [5:0]  irq_lvl;
    logic [5:0]  irq_en;
  } main_st_t;

  main_st_t   st_ff;
  main_st_t   nxt_st;
  base_sel_t  base_sel;
  irq_level_t irq_level;
  logic       edge_fall;
  src_sel_t   src_sel;
  logic       irq_req;
  logic       src;
  logic       hit;
  logic [2:0] live_state;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Card select from the synchronised address and base selector
  function automatic logic card_hit(input logic [9:0] addr, input base_sel_t base);
    return base[`BASE_RANGE_BIT] && (base <= `BASE_SEL_MAX) && (addr[9:2] == base);
  endfunction : card_hit

  // Input byte seen at one of the four ports
  function automatic logic [7:0] port_read(input logic [1:0] port, input logic [15:0] iso,
                                           input logic [15:0] ttl);
    logic [7:0] r;
    r = 8'h00;
    unique case (port)
      `ISA_OFS_ISO_LO: r = iso[7:0];
      `ISA_OFS_ISO_HI: r = iso[15:8];
      `ISA_OFS_TTL_LO: r = ttl[7:0];
      `ISA_OFS_TTL_HI: r = ttl[15:8];
    endcase
    return r;
  endfunction : port_read

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  assign live_state = {st_ff.rd_oe, st_ff.fsm != ISA_IDLE, src};

  axi_cfg_regs u_cfg (
    .mclk          (mclk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .evt           ({st_ff.wr_ev, st_ff.edge_ev}),
    .live_state    (live_state),
    .base_sel      (base_sel),
    .irq_level     (irq_level),
    .edge_fall     (edge_fall),
    .src_sel       (src_sel),
    .irq_req       (irq_req)
  );

  // ****************************************************************
  // Decode, cycle tracking and interrupt source
  // ****************************************************************

  // Decode only from second-stage samples, never from the first
  assign hit = card_hit(st_ff.sa_s2, base_sel);

  // Source selection among the two isolated and two TTL channel zeros/ones
  always_comb begin
    src = st_ff.iso_s2[0];
    unique case (src_sel)
      2'h0: src = st_ff.iso_s2[0];
      2'h1: src = st_ff.iso_s2[1];
      2'h2: src = st_ff.ttl_s2[0];
      2'h3: src = st_ff.ttl_s2[1];
    endcase
  end

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronisers for every pin that comes from the bus or field
    nxt_st.sa_s1 = sa;
    nxt_st.sa_s2 = st_ff.sa_s1;
    nxt_st.sd_s1 = sd_in;
    nxt_st.sd_s2 = st_ff.sd_s1;
    nxt_st.ior_n_s1 = ior_n;
    nxt_st.ior_n_s2 = st_ff.ior_n_s1;
    nxt_st.iow_n_s1 = iow_n;
    nxt_st.iow_n_s2 = st_ff.iow_n_s1;
    nxt_st.iso_s1 = isolated_input;
    nxt_st.iso_s2 = st_ff.iso_s1;
    nxt_st.ttl_s1 = ttl_input;
    nxt_st.ttl_s2 = st_ff.ttl_s1;
    nxt_st.wr_ev = 1'b0;

    unique case (st_ff.fsm)
      ISA_IDLE: begin
        // A cycle starts only with a strobe inside the block
        if (hit && !st_ff.ior_n_s2) begin
          nxt_st.fsm = ISA_READ;
          nxt_st.rd_port = st_ff.sa_s2[1:0];
          nxt_st.rd_data = port_read(st_ff.sa_s2[1:0], st_ff.iso_s2, st_ff.ttl_s2);
          nxt_st.rd_oe = 1'b1;
        end else if (hit && !st_ff.iow_n_s2) begin
          nxt_st.fsm = ISA_WRITE;
          nxt_st.wr_port = st_ff.sa_s2[1:0];
          nxt_st.wr_data = st_ff.sd_s2;
        end
      end
      ISA_READ: begin
        // Inputs keep tracking while the read strobe is held
        if (st_ff.ior_n_s2) begin
          nxt_st.fsm = ISA_IDLE;
          nxt_st.rd_oe = 1'b0;
        end else begin
          nxt_st.rd_data = port_read(st_ff.rd_port, st_ff.iso_s2, st_ff.ttl_s2);
        end
      end
      ISA_WRITE: begin
        // Data is committed at strobe release, from the last sample inside it,
        // because the bus may drop data as soon as the strobe ends
        if (st_ff.iow_n_s2) begin
          nxt_st.fsm = ISA_IDLE;
          nxt_st.wr_ev = 1'b1;
          unique case (st_ff.wr_port)
            `ISA_OFS_ISO_LO: nxt_st.iso_out[7:0] = st_ff.wr_data;
            `ISA_OFS_ISO_HI: nxt_st.iso_out[15:8] = st_ff.wr_data;
            `ISA_OFS_TTL_LO: nxt_st.ttl_out[7:0] = st_ff.wr_data;
            `ISA_OFS_TTL_HI: nxt_st.ttl_out[15:8] = st_ff.wr_data;
          endcase
        end else begin
          nxt_st.wr_data = st_ff.sd_s2;
        end
      end
      default: begin
        nxt_st.fsm = ISA_IDLE;
        nxt_st.rd_oe = 1'b0;
      end
    endcase

    // Edge detector; a change of source selector can also look like an edge
    nxt_st.src_prev = src;
    nxt_st.edge_ev = edge_fall ? (!src && st_ff.src_prev)
                               : (src && !st_ff.src_prev);

    // Route the request to the one selected line, or to none
    for (int i = 0; i < `IRQ_LINES; i++) begin
      nxt_st.irq_en[i] = (irq_level == 3'(i));
      nxt_st.irq_lvl[i] = irq_req && (irq_level == 3'(i));
    end
  end

  // Register the whole state; outputs restart released and cleared
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ior_n_s1 <= 1'b1;
      st_ff.ior_n_s2 <= 1'b1;
      st_ff.iow_n_s1 <= 1'b1;
      st_ff.iow_n_s2 <= 1'b1;
      st_ff.fsm <= ISA_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sd_out          = st_ff.rd_data;
  assign sd_oe           = st_ff.rd_oe;
  assign irq_out         = st_ff.irq_lvl;
  assign irq_oe          = st_ff.irq_en;
  assign isolated_output = st_ff.iso_out;
  assign ttl_output      = st_ff.ttl_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Read drive only follows a strobe inside the selected block
  property p_drive_needs_hit;
    $rose(sd_oe) |-> $past(hit) && !$past(st_ff.ior_n_s2);
  endproperty
  a_drive_needs_hit: assert property (p_drive_needs_hit)
    else $error("bus driven without a decoded read");

  // Base below 200h or above 3F0h never answers
  property p_low_base_silent;
    ((!base_sel[`BASE_RANGE_BIT] || base_sel > `BASE_SEL_MAX) && st_ff.fsm == ISA_IDLE)
      |=> !sd_oe && !st_ff.wr_ev;
  endproperty
  a_low_base_silent: assert property (p_low_base_silent)
    else $error("card answered with base out of range");

  // Selector comes out of reset at 300h
  property p_base_reset;
    $past(rst) |-> base_sel == `BASE_SEL_RESET;
  endproperty
  a_base_reset: assert property (@(posedge mclk) p_base_reset)
    else $error("base selector not at 300h after reset");

  // Matching A9..A2 with a read strobe is answered on the next edge
  property p_match_answers;
    (st_ff.fsm == ISA_IDLE && !st_ff.ior_n_s2 && st_ff.sa_s2[9:2] == base_sel
     && base_sel[`BASE_RANGE_BIT] && base_sel <= `BASE_SEL_MAX)
      |=> sd_oe ##1 (sd_oe || st_ff.ior_n_s2);
  endproperty
  a_match_answers: assert property (p_match_answers)
    else $error("matching read not answered");

  // Without a strobe the tracker stays idle
  property p_strobe_needed;
    (st_ff.fsm == ISA_IDLE && st_ff.ior_n_s2 && st_ff.iow_n_s2) |=> st_ff.fsm == ISA_IDLE;
  endproperty
  a_strobe_needed: assert property (p_strobe_needed)
    else $error("cycle started without a strobe");

  // At most one line enabled, none when disabled
  property p_one_line;
    $onehot0(irq_oe) and (irq_level >= `IRQ_LEVEL_OFF |=> irq_oe == 6'h00);
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("interrupt routed to a wrong number of lines");

  // With the rising edge selected, an event follows a rise of the source
  property p_edge_kind;
    (st_ff.edge_ev && $past(!edge_fall)) |-> $past(src) && !$past(st_ff.src_prev);
  endproperty
  a_edge_kind: assert property (p_edge_kind)
    else $error("interrupt event on the wrong edge");

  // A synchronised rise on TTL channel 0, when selected, gives an event on the next edge
  property p_ttl0_source;
    (src_sel == 2'h2 && !edge_fall && st_ff.ttl_s2[0] && !$past(st_ff.ttl_s2[0])
     && $stable(src_sel)) |=> st_ff.edge_ev;
  endproperty
  a_ttl0_source: assert property (p_ttl0_source)
    else $error("selected source edge missed");

  // A write to the low isolated port lands on the outputs at release
  property p_write_lands;
    (st_ff.fsm == ISA_WRITE && st_ff.iow_n_s2 && st_ff.wr_port == `ISA_OFS_ISO_LO)
      |=> isolated_output[7:0] == $past(st_ff.wr_data) && st_ff.fsm == ISA_IDLE;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("written byte not on isolated outputs");

  // Main scenarios
  c_read:  cover property ($rose(sd_oe));
  c_write: cover property (st_ff.wr_ev);
  c_edge:  cover property (st_ff.edge_ev);
  c_irq:   cover property ($rose(|irq_out));
endmodule : isa_dio_decode_irq
`default_nettype wire
